/* File: include/azrs_pkg.sv */
// package for the auto-zero rate sequencer: ratios, timing and carrier types
package azrs_pkg;
   localparam int unsigned AZRS_REF_HZ = 200_000_000;
   localparam int unsigned AZRS_OSC_HZ = 100_000;
   // ref cycles per internal oscillator tick, rounded down
   localparam int unsigned AZRS_OSC_DIV = AZRS_REF_HZ / AZRS_OSC_HZ;
   localparam logic [10:0] AZRS_OSC_LAST = 11'(AZRS_OSC_DIV - 1);
   localparam int AZRS_DIV_W = 10;
   localparam logic [AZRS_DIV_W-1:0] AZRS_DIV_1 = 10'h000;
   localparam logic [AZRS_DIV_W-1:0] AZRS_DIV_4 = 10'h003;
   localparam logic [AZRS_DIV_W-1:0] AZRS_DIV_16 = 10'h00f;
   localparam logic [AZRS_DIV_W-1:0] AZRS_DIV_128 = 10'h07f;
   localparam logic [AZRS_DIV_W-1:0] AZRS_DIV_1024 = 10'h3ff;
   localparam int AZRS_STAGES = 4;
   localparam logic [1:0] AZRS_STAGE_LAST = 2'(AZRS_STAGES - 1);

   typedef enum {
      AZRS_IDLE,
      AZRS_ZERO,
      AZRS_DECIDE,
      AZRS_STEP
   } azrs_seq_t;

   typedef struct packed {
      logic [10:0] osc_cnt;
      logic clk_in_q;
      logic [AZRS_DIV_W-1:0] div_cnt;
      logic toggled;
      logic decision;
      logic decided_once;
      logic [1:0] stage;
      logic step_up;
      logic step_down;
      logic sample_pend;
      azrs_seq_t seq;
   } azrs_state_t;
endpackage : azrs_pkg

/* File: tb/azrs_node_model.sv */
// behavioural summing node: integrates correction steps, compares with ground
module azrs_node_model #(
   parameter int START = -3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic step_up,
   input wire logic step_down,
   output logic compare_high
);
   timeunit 1ns;
   timeprecision 1ps;
   int level;
   always_ff @(posedge clk) begin
      if (rst)
         level <= START;
      else
         level <= level + int'(step_up) - int'(step_down);
   end
   // node exactly at ground reads low, so null dithers by one step
   assign compare_high = level > 0;
endmodule : azrs_node_model

/* File: tb/test_auto_zero_rate_sequencer.sv */
// testbench: rate selection, first-toggle switch, sample walk and clock stop
module test_auto_zero_rate_sequencer;
   import azrs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, reset_n = 1, sel_a = 1, sel_b = 1, osc_stop = 0;
   logic cmp, le, dec_oe_n, up, down, tick, fast;
   int err_count = 0, check_count = 0, gap;
   logic ext_sel = 0, ext_clk = 0, sz, dec_o;
   logic [1:0] idx;
   localparam int EXT_HALF = 1200;
   int ext_cnt = 0;
   initial forever #2.5 clk = ~clk;
   // external clock of 2 * EXT_HALF ref cycles, about 83 kHz
   always @(posedge clk) begin
      ext_cnt <= (ext_cnt == 2 * EXT_HALF - 1) ? 0 : ext_cnt + 1;
      ext_clk <= (ext_cnt < EXT_HALF);
   end
   azrs_sequencer u_dut (.REF_CLK(clk), .RST(rst), .RESET_N(reset_n),
      .RATE_SELECT_A(sel_a), .RATE_SELECT_B(sel_b), .EXT_CLK_SEL(ext_sel),
      .EXT_CLK(ext_clk), .OSC_STOP(osc_stop), .COMPARE_HIGH(cmp), .STAGE_ZERO(sz),
      .STAGE_INDEX(idx), .LATCH_ENABLE(le), .DECISION_OUTPUT_O(dec_o),
      .DECISION_OUTPUT_OE_N(dec_oe_n), .STEP_UP(up), .STEP_DOWN(down),
      .SAMPLE_TICK(tick), .FAST_RATE(fast));
   azrs_node_model u_node (.clk(clk), .rst(rst), .step_up(up), .step_down(down),
      .compare_high(cmp));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // one sample: checks its walk, returns cycles since the previous one
   task automatic wait_tick(output int g);
      logic c;
      g = 8;
      while (tick !== 1'b1) begin
         @(posedge clk);
         #1;
         g++;
         if (g > 40000) begin
            err_count++;
            end_of_test();
         end
      end
      c = cmp;
      @(posedge clk);
      #1;
      for (int k = 0; k < AZRS_STAGES; k++) begin
         @(posedge clk);
         #1;
         chk(sz, 1'b1);
         chk(idx, k);
      end
      @(posedge clk);
      #1;
      chk(sz, 1'b0);
      @(posedge clk);
      #1;
      chk(dec_oe_n, c);
      chk(le, 1'b1);
      chk(dec_o, 1'b0);
      @(posedge clk);
      #1;
      chk({up, down}, {~c, c});
   endtask : wait_tick
   initial begin
      void'($urandom(80460));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      // node starts three steps low: the fifth decision is the first change
      for (int i = 1; i <= 5; i++) begin
         if (i > 1)
            chk(fast, 1'b1);
         wait_tick(gap);
         if (i > 1)
            chk(gap, AZRS_OSC_DIV);
      end
      chk(fast, 1'b0);
      wait_tick(gap);
      wait_tick(gap);
      chk(gap, 4 * AZRS_OSC_DIV);
      // one edge goes to changing the selects, so the gap counts one short
      @(posedge clk);
      {sel_a, sel_b} <= 2'b10;
      wait_tick(gap);
      chk(gap + 1, 16 * AZRS_OSC_DIV);
      $display("test rate switch done");
      @(posedge clk);
      reset_n <= 1'b0;
      {sel_a, sel_b} <= 2'($urandom);
      for (int i = 0; i < 3; i++) begin
         wait_tick(gap);
         if (i > 0)
            chk(gap, AZRS_OSC_DIV);
         chk(fast, 1'b1);
      end
      $display("test device reset done");
      @(posedge clk);
      reset_n <= 1'b1;
      osc_stop <= 1'b1;
      gap = 0;
      repeat (6000) begin
         @(posedge clk);
         #1;
         gap += int'(tick);
      end
      chk(gap, 0);
      osc_stop <= 1'b0;
      wait_tick(gap);
      wait_tick(gap);
      chk(gap, AZRS_OSC_DIV);
      $display("test clock stop done");
      @(posedge clk);
      reset_n <= 1'b0;
      ext_sel <= 1'b1;
      wait_tick(gap);
      wait_tick(gap);
      chk(gap, 2 * EXT_HALF);
      $display("test external clock done");
      end_of_test();
   end
endmodule : test_auto_zero_rate_sequencer

/* File: verilog/azrs_sequencer.sv */
// auto-zero rate sequencer: clock source, rate divider, sample/correct sequencer

// Behaviour
// - reset inactive: rate selects 11->/4, 10->/16, 01->/128, 00->/1024
// - while reset is low the divider divides by one
// - programmed ratio applies only after the latched decision first changes
// - rate selects may change anytime; new ratio applies from then on
// - decision output latched, updated once per sample
// - latch holds the decision, and output shows it at that moment
// - off-null sample issues one step opposite to the error, every sample
// - sampling and correction continue every period after null
// - comparator stages zeroed one after another before deciding
// - power-up and every reset fall back to divide by one
// - each divider output pulse starts one sequencer run
module azrs_sequencer
   import azrs_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic RESET_N,
   input wire logic RATE_SELECT_A,
   input wire logic RATE_SELECT_B,
   input wire logic EXT_CLK_SEL,
   input wire logic EXT_CLK,
   input wire logic OSC_STOP,
   input wire logic COMPARE_HIGH,
   output logic STAGE_ZERO,
   output logic [1:0] STAGE_INDEX,
   output logic LATCH_ENABLE,
   output logic DECISION_OUTPUT_O,
   output logic DECISION_OUTPUT_OE_N,
   output logic STEP_UP,
   output logic STEP_DOWN,
   output logic SAMPLE_TICK,
   output logic FAST_RATE
);
   azrs_state_t st;
   azrs_state_t next_st;
   logic [AZRS_DIV_W-1:0] ratio;
   logic src_tick;
   logic div_tick;

   always_comb begin
      // reset low or no toggle yet keeps the fastest rate
      if (!RESET_N || !st.toggled) begin
         ratio = AZRS_DIV_1;
      end else begin
         // live decode so a changed select takes effect at once, in the period in progress
         case ({RATE_SELECT_A, RATE_SELECT_B})
            2'b11: ratio = AZRS_DIV_4;
            2'b10: ratio = AZRS_DIV_16;
            2'b01: ratio = AZRS_DIV_128;
            default: ratio = AZRS_DIV_1024;
         endcase
      end
   end

   // external edge or internal oscillator wrap; stop level freezes the oscillator
   // edge found against the registered level, so it shows in the first ref cycle the input is high
   assign src_tick = EXT_CLK_SEL ? (EXT_CLK && !st.clk_in_q)
      : (!OSC_STOP && st.osc_cnt == AZRS_OSC_LAST);
   // counter may sit above a newly shortened ratio; >= wraps it on the next source tick
   assign div_tick = src_tick && (st.div_cnt >= ratio);

   always_comb begin
      next_st = st;
      next_st.clk_in_q = EXT_CLK;
      next_st.step_up = 1'b0;
      next_st.step_down = 1'b0;
      if (!EXT_CLK_SEL && !OSC_STOP) begin
         next_st.osc_cnt = (st.osc_cnt == AZRS_OSC_LAST) ? 11'h000 : st.osc_cnt + 11'h001;
      end
      if (src_tick) begin
         next_st.div_cnt = div_tick ? AZRS_DIV_1 : st.div_cnt + 10'h001;
      end
      // a pulse arriving mid-run is remembered so no sample is skipped
      if (div_tick) begin
         next_st.sample_pend = 1'b1;
      end
      case (st.seq)
         AZRS_IDLE: begin
            if (st.sample_pend) begin
               next_st.sample_pend = div_tick;
               next_st.stage = 2'h0;
               next_st.seq = AZRS_ZERO;
            end
         end
         AZRS_ZERO: begin
            next_st.stage = st.stage + 2'h1;
            if (st.stage == AZRS_STAGE_LAST) begin
               next_st.seq = AZRS_DECIDE;
            end
         end
         AZRS_DECIDE: begin
            next_st.decision = COMPARE_HIGH;
            next_st.decided_once = 1'b1;
            if (st.decided_once && COMPARE_HIGH != st.decision) begin
               next_st.toggled = 1'b1;
            end
            next_st.seq = AZRS_STEP;
         end
         AZRS_STEP: begin
            // node above ground steps down, below steps up
            next_st.step_down = st.decision;
            next_st.step_up = !st.decision;
            next_st.seq = AZRS_IDLE;
         end
         default: next_st.seq = AZRS_IDLE;
      endcase
      if (!RESET_N) begin
         next_st.toggled = 1'b0;
         next_st.decided_once = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         st <= '0;
         st.seq <= AZRS_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign STAGE_ZERO = (st.seq == AZRS_ZERO);
   assign STAGE_INDEX = st.stage;
   assign LATCH_ENABLE = (st.seq == AZRS_STEP);
   assign DECISION_OUTPUT_O = 1'b0;
   // open drain: enable low pulls the pin low when decision is low
   assign DECISION_OUTPUT_OE_N = st.decision;
   assign STEP_UP = st.step_up;
   assign STEP_DOWN = st.step_down;
   assign SAMPLE_TICK = div_tick;
   assign FAST_RATE = (ratio == AZRS_DIV_1);

   a_fast_in_reset: assert property (@(posedge REF_CLK) disable iff (RST)
      !RESET_N |-> FAST_RATE)
      else $error("ratio not one while reset low");
   a_flag_clear: assert property (@(posedge REF_CLK) disable iff (RST)
      !RESET_N |=> !st.toggled)
      else $error("toggle flag survived reset");
   a_ratio_decode: assert property (@(posedge REF_CLK) disable iff (RST)
      (RESET_N && st.toggled && RATE_SELECT_A && RATE_SELECT_B) |-> ratio == AZRS_DIV_4)
      else $error("wrong ratio for both selects high");
   a_step_after: assert property (@(posedge REF_CLK) disable iff (RST)
      (st.seq == AZRS_STEP) |=> (STEP_UP ^ STEP_DOWN) && (STEP_DOWN == $past(st.decision)))
      else $error("step missing or wrong direction");
   a_stage_walk: assert property (@(posedge REF_CLK) disable iff (RST)
      (st.seq == AZRS_IDLE && st.sample_pend) |=> STAGE_ZERO [*4] ##1 st.seq == AZRS_DECIDE)
      else $error("stage zeroing sequence broken");
   a_out_follows: assert property (@(posedge REF_CLK) disable iff (RST)
      (st.seq == AZRS_DECIDE) |=> DECISION_OUTPUT_OE_N == $past(COMPARE_HIGH))
      else $error("decision output not updated");
   a_toggle_set: assert property (@(posedge REF_CLK) disable iff (RST)
      (RESET_N && st.seq == AZRS_DECIDE && st.decided_once && COMPARE_HIGH != st.decision)
      |=> st.toggled)
      else $error("first toggle not recorded");
   a_run_starts: assert property (@(posedge REF_CLK) disable iff (RST)
      (div_tick && st.seq == AZRS_IDLE && !st.sample_pend) |=> ##1 STAGE_ZERO)
      else $error("divider pulse did not start a run");
   a_hold_between: assert property (@(posedge REF_CLK) disable iff (RST)
      (st.seq != AZRS_DECIDE) |=> $stable(st.decision))
      else $error("decision changed outside a decision");
   // guards for the remaining ratios, sequencing and clock source

   a_ratio_sixteen: assert property (@(posedge REF_CLK) disable iff (RST)
      (RESET_N && st.toggled && RATE_SELECT_A && !RATE_SELECT_B) |-> ratio == AZRS_DIV_16)
      else $error("wrong ratio for first select only");

   a_ratio_slow: assert property (@(posedge REF_CLK) disable iff (RST)
      (RESET_N && st.toggled && !RATE_SELECT_A && RATE_SELECT_B) |-> ratio == AZRS_DIV_128)
      else $error("wrong ratio for second select only");

   a_ratio_slowest: assert property (@(posedge REF_CLK) disable iff (RST)
      (RESET_N && st.toggled && !RATE_SELECT_A && !RATE_SELECT_B) |-> ratio == AZRS_DIV_1024)
      else $error("wrong ratio for both selects low");

   a_fast_before: assert property (@(posedge REF_CLK) disable iff (RST)
      !st.toggled |-> FAST_RATE)
      else $error("programmed ratio used before first toggle");

   a_short_wrap: assert property (@(posedge REF_CLK) disable iff (RST)
      (src_tick && st.div_cnt >= ratio) |=> st.div_cnt == AZRS_DIV_1)
      else $error("divider did not wrap on a shortened ratio");

   a_latch_single: assert property (@(posedge REF_CLK) disable iff (RST)
      LATCH_ENABLE |=> !LATCH_ENABLE)
      else $error("latch enable longer than one cycle");

   a_step_origin: assert property (@(posedge REF_CLK) disable iff (RST)
      (STEP_UP || STEP_DOWN) |-> $past(LATCH_ENABLE))
      else $error("step without a latched decision");

   a_null_resume: assert property (@(posedge REF_CLK) disable iff (RST)
      (st.seq == AZRS_STEP) |=> (st.seq == AZRS_IDLE))
      else $error("sequencer did not return to idle");

   a_osc_frozen: assert property (@(posedge REF_CLK) disable iff (RST)
      (!EXT_CLK_SEL && OSC_STOP) |-> !src_tick)
      else $error("source tick while oscillator stopped");

   a_osc_hold: assert property (@(posedge REF_CLK) disable iff (RST)
      (!EXT_CLK_SEL && OSC_STOP) |=> $stable(st.osc_cnt))
      else $error("oscillator count moved while stopped");

   a_stage_step: assert property (@(posedge REF_CLK) disable iff (RST)
      (STAGE_ZERO && st.stage != AZRS_STAGE_LAST) |=> STAGE_INDEX == $past(STAGE_INDEX) + 2'h1)
      else $error("stage index skipped");

   // a tick lasting two cycles would leave a sample pending and start two sequencer runs
   a_tick_single: assert property (@(posedge REF_CLK) disable iff (RST)
      SAMPLE_TICK |=> !SAMPLE_TICK)
      else $error("sample tick longer than one cycle");

   a_flag_keep: assert property (@(posedge REF_CLK) disable iff (RST)
      (RESET_N && st.toggled) |=> st.toggled)
      else $error("toggle flag lost without reset");
endmodule : azrs_sequencer
